// >>> ppcl_pkg.sv
// Package with register map, reset values and carrier types for the port block.
package ppcl_pkg;

  localparam int unsigned PPCL_ADDR_W = 8;
  localparam int unsigned PPCL_DATA_W = 8;
  localparam int unsigned PPCL_PINS   = 8;

  localparam logic [7:0] PPCL_ADDR_P0_DRIVE   = 8'hd9;
  localparam logic [7:0] PPCL_ADDR_P4_LATCH   = 8'he2;
  localparam logic [7:0] PPCL_ADDR_P1_ANALOG  = 8'hed;

  localparam logic [7:0] PPCL_RST_P0_DRIVE  = 8'h00;
  localparam logic [7:0] PPCL_RST_P4_LATCH  = 8'hff;
  localparam logic [7:0] PPCL_RST_P1_ANALOG = 8'hff;
  localparam logic [7:0] PPCL_UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppcl_sfr_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } ppcl_pin_drive_t;

endpackage

// >>> ppcl_port_pin_config_latch.sv
// Port pin configuration and latch logic reached over the SFR bus.
`timescale 1ns/1ps

module ppcl_port_pin_config_latch
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // SFR bus
  input  wire ppcl_pkg::ppcl_sfr_req_t   sfr_req,
  output      logic [7:0]                sfr_rdata,
  output      logic                      sfr_hit,
  // Port 0 pads
  input  wire logic [7:0]                p0_latch,
  input  wire logic [7:0]                p0_pin_in,
  output      ppcl_pkg::ppcl_pin_drive_t p0_drive,
  output      logic [7:0]                p0_pullup_en,
  // Port 1 pads
  input  wire logic [7:0]                p1_pin_in,
  output      logic [7:0]                p1_digital_in,
  output      logic [7:0]                p1_pullup_en,
  output      logic [7:0]                p1_driver_en,
  // Port 4 pads
  input  wire logic [7:0]                p4_pin_in,
  output      ppcl_pkg::ppcl_pin_drive_t p4_drive
);
  import ppcl_pkg::*;

  // Configuration and latch registers.
  logic [7:0] p0_drive_select_q;
  logic [7:0] p1_analog_select_q;
  logic [7:0] p4_latch_q;

  // Pad synchroniser stages, one pair per port.
  logic [7:0] p0_meta_q;
  logic [7:0] p0_sync_q;
  logic [7:0] p1_meta_q;
  logic [7:0] p1_sync_q;
  logic [7:0] p4_meta_q;
  logic [7:0] p4_sync_q;

  // Decoded write strobes, one per register.
  logic       wr_drive_sel;
  logic       wr_analog_sel;
  logic       wr_latch;

  // A write to an unmapped address raises no strobe and is dropped.
  always_comb
  begin
    wr_drive_sel  = 1'b0;
    wr_analog_sel = 1'b0;
    wr_latch      = 1'b0;
    if (sfr_req.wr)
    begin
      unique case (sfr_req.addr)
        PPCL_ADDR_P0_DRIVE:
        begin
          wr_drive_sel = 1'b1;
        end
        PPCL_ADDR_P1_ANALOG:
        begin
          wr_analog_sel = 1'b1;
        end
        PPCL_ADDR_P4_LATCH:
        begin
          wr_latch = 1'b1;
        end
        default:
        begin
          wr_latch = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      p0_drive_select_q <= PPCL_RST_P0_DRIVE;
    end
    else if (wr_drive_sel)
    begin
      p0_drive_select_q <= sfr_req.wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      p1_analog_select_q <= PPCL_RST_P1_ANALOG;
    end
    else if (wr_analog_sel)
    begin
      p1_analog_select_q <= sfr_req.wdata;
    end
  end

  // Port 4 has no mode register here, so every pin counts as digital I/O.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      p4_latch_q <= PPCL_RST_P4_LATCH;
    end
    else if (wr_latch)
    begin
      p4_latch_q <= sfr_req.wdata;
    end
  end

  // Pads are asynchronous, so two flops precede any reader.
  // Port 0 stages have no reader yet; they keep every pad path alike.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      p0_meta_q <= 8'h00;
      p0_sync_q <= 8'h00;
    end
    else
    begin
      p0_meta_q <= p0_pin_in;
      p0_sync_q <= p0_meta_q;
    end
  end

  // Port 1 stages feed only the digital receiver.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      p1_meta_q <= 8'h00;
      p1_sync_q <= 8'h00;
    end
    else
    begin
      p1_meta_q <= p1_pin_in;
      p1_sync_q <= p1_meta_q;
    end
  end

  // Port 4 stages reset high, the level of a released pad, so the
  // readback shows no false low just after reset.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      p4_meta_q <= 8'hff;
      p4_sync_q <= 8'hff;
    end
    else
    begin
      p4_meta_q <= p4_pin_in;
      p4_sync_q <= p4_meta_q;
    end
  end

  // Port 4 reads show the pad level, so a pin held low externally reads 0 even
  // when its latch holds 1; read-modify-write code must allow for that.
  always_comb
  begin
    sfr_hit   = 1'b0;
    sfr_rdata = PPCL_UNMAPPED_READ;
    unique case (sfr_req.addr)
      PPCL_ADDR_P0_DRIVE:
      begin
        sfr_hit   = 1'b1;
        sfr_rdata = p0_drive_select_q;
      end
      PPCL_ADDR_P1_ANALOG:
      begin
        sfr_hit   = 1'b1;
        sfr_rdata = p1_analog_select_q;
      end
      PPCL_ADDR_P4_LATCH:
      begin
        sfr_hit   = 1'b1;
        sfr_rdata = p4_sync_q;
      end
      default:
      begin
        sfr_hit   = 1'b0;
        sfr_rdata = PPCL_UNMAPPED_READ;
      end
    endcase
  end

  genvar gi;

  // Port 0: push-pull drives both levels, open-drain only pulls low.
  generate
    for (gi = 0; gi < PPCL_PINS; gi++)
    begin : g_p0_pin
      assign p0_drive.out[gi]  = p0_latch[gi];
      assign p0_drive.oe_n[gi] = ~p0_drive_select_q[gi]
                                 & p0_latch[gi];
      assign p0_pullup_en[gi]  = 1'b1;
    end
  endgenerate

  // Port 1: analog mode removes pullup, driver and receiver.
  generate
    for (gi = 0; gi < PPCL_PINS; gi++)
    begin : g_p1_pin
      assign p1_digital_in[gi] = p1_analog_select_q[gi]
                                 & p1_sync_q[gi];
      assign p1_pullup_en[gi]  = p1_analog_select_q[gi];
      assign p1_driver_en[gi]  = p1_analog_select_q[gi];
    end
  endgenerate

  // Port 4: latch 0 pulls low, latch 1 releases to the pullup.
  generate
    for (gi = 0; gi < PPCL_PINS; gi++)
    begin : g_p4_pin
      assign p4_drive.out[gi]  = p4_latch_q[gi];
      assign p4_drive.oe_n[gi] = p4_latch_q[gi];
    end
  endgenerate

endmodule // ppcl_port_pin_config_latch

// >>> ppcl_sva.sv
// Checker for the port pin configuration and latch block.
`timescale 1ns/1ps
module ppcl_sva
(
  // Clock and reset
  input wire logic                      mclk,
  input wire logic                      reset,
  // Register bus
  input wire ppcl_pkg::ppcl_sfr_req_t   sfr_req,
  input wire logic [7:0]                sfr_rdata,
  // Pin drive and pad levels
  input wire ppcl_pkg::ppcl_pin_drive_t p0_drive,
  input wire ppcl_pkg::ppcl_pin_drive_t p4_drive,
  input wire logic [7:0]                p0_latch,
  input wire logic [7:0]                p4_pin_in,
  // Port 1 mode outputs
  input wire logic [7:0]                p1_digital_in,
  input wire logic [7:0]                p1_pullup_en,
  input wire logic [7:0]                p1_driver_en
);
  import ppcl_pkg::*;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_drive_mode: assert property (
    (sfr_req.wr && sfr_req.addr == PPCL_ADDR_P0_DRIVE)
    |=> p0_drive.oe_n == (~$past(sfr_req.wdata) & p0_latch))
    else $error("Port 0 output enable does not follow drive select.");
  a_mode_set: assert property (
    (sfr_req.wr && sfr_req.addr == PPCL_ADDR_P1_ANALOG)
    |=> p1_driver_en == $past(sfr_req.wdata))
    else $error("Port 1 mode does not follow the written value.");
  a_analog_off: assert property (
    p1_pullup_en == p1_driver_en
    && (p1_digital_in & ~p1_driver_en) == 8'h00)
    else $error("Analog pin still has a digital path enabled.");
  a_low_drive: assert property (
    (~p4_drive.oe_n & p4_drive.out) == 8'h00)
    else $error("Port 4 drives a pin high.");
  a_latch_wr: assert property (
    (sfr_req.wr && sfr_req.addr == PPCL_ADDR_P4_LATCH)
    |=> p4_drive.out == $past(sfr_req.wdata))
    else $error("Port 4 latch does not take the written value.");
  a_latch_hold: assert property (
    !(sfr_req.wr && sfr_req.addr == PPCL_ADDR_P4_LATCH)
    |=> $stable(p4_drive.out))
    else $error("Port 4 latch changed without a write.");
  a_pin_read: assert property (
    ($stable(p4_pin_in)[*3] ##0 sfr_req.addr == PPCL_ADDR_P4_LATCH)
    |-> sfr_rdata == p4_pin_in)
    else $error("Port 4 read does not show the pad level.");
endmodule // ppcl_sva
bind ppcl_port_pin_config_latch ppcl_sva i_ppcl_sva (.*);

// >>> ppcl_pad_model.sv
// Pad model for port 4 with a weak pullup and outside pull-downs.
`timescale 1ns/1ps
module ppcl_pad_model
(
  // Drive from the block and from outside
  input  wire ppcl_pkg::ppcl_pin_drive_t p4_drive,
  input  wire logic [7:0]                ext_low,
  // Resolved pad level
  output      logic [7:0]                p4_pin_in
);
  // A released pad floats high, so any outside low wins over it.
  assign p4_pin_in = ~((~p4_drive.oe_n & ~p4_drive.out) | ext_low);
endmodule // ppcl_pad_model

// >>> tb_top.sv
// Testbench for the port pin configuration and latch block.
`timescale 1ns/1ps
module tb_top;
  import ppcl_pkg::*;
  logic mclk = 0, reset = 1, hit;
  ppcl_sfr_req_t rq = '0;
  ppcl_pin_drive_t d0, d4;
  logic [7:0] rd, l0 = 8'hff, p1i = 8'hff, xl = 8'h00, p4i, pu0, pu1, dr1, di1;
  int error_cnt = 0, num_checks = 0;
  ppcl_port_pin_config_latch i_ppcl_port_pin_config_latch (.mclk, .reset,
    .sfr_req(rq), .sfr_rdata(rd), .sfr_hit(hit), .p0_latch(l0),
    .p0_pin_in(8'h00), .p0_drive(d0), .p0_pullup_en(pu0), .p1_pin_in(p1i),
    .p1_digital_in(di1), .p1_pullup_en(pu1), .p1_driver_en(dr1),
    .p4_pin_in(p4i), .p4_drive(d4));
  ppcl_pad_model i_ppcl_pad_model (.p4_drive(d4), .ext_low(xl),
    .p4_pin_in(p4i));
  initial forever #50 mclk = ~mclk;
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // Entered just after an edge; one idle edge follows each write so that
  // the next call never lowers and raises the strobe in one time step.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    rq = '{1'b1, 1'b0, a, d};
    @(posedge mclk) #1 rq.wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [7:0] e);
    rq = '{1'b0, 1'b1, a, 8'h00};
    #10 chk(n, e, rd);
    @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    rdc("drv", 8'hd9, 8'h00);
    rdc("pin", 8'he2, 8'hff);
    chk("hit", 8'h01, {7'h00, hit});
    rdc("mode", 8'hed, 8'hff);
    $display("reset done");
  endtask
  task automatic t_cfg();
    wr(8'hd9, 8'h0f);
    wr(8'hed, 8'h5a);
    l0 = 8'h33;
    repeat (2) @(posedge mclk);
    #1 chk("oe0", 8'h30, d0.oe_n);
    chk("out0", 8'h33, d0.out);
    chk("pu0", 8'hff, pu0);
    chk("din", 8'h5a, di1);
    chk("pull", 8'h5a, pu1);
    chk("drv1", 8'h5a, dr1);
    p1i = 8'h0f;
    repeat (2) @(posedge mclk);
    #1 chk("din_lo", 8'h0a, di1);
    rdc("drv", 8'hd9, 8'h0f);
    $display("cfg done");
  endtask
  task automatic t_latch();
    wr(8'he2, 8'h0f);
    xl = 8'h81;
    repeat (3) @(posedge mclk);
    #1 chk("oe4", 8'h0f, d4.oe_n);
    chk("out4", 8'h0f, d4.out);
    rdc("pin", 8'he2, 8'h0e);
    $display("latch done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    #1 reset = 1'b0;
    t_reset();
    t_cfg();
    t_latch();
    wrap_up();
  end
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb_top
